// [verilog/bah_device.v]
// Device end of the bus allocation handshake: bid, acquire, lock
`timescale 1ns/1ps
`default_nettype none
`include "bah_map.vh"

// Operation
// R1: bid only when unlocked, grant and reset quiet
// R2: arbiter allocates by joining an active bid
// R3: response level at deallocate selects its meaning
// R4: arbiter raises grant after allocation
// R5: arbiter grants without bid to deallocate
// R6: drop bid on grant or reset
// R7: acquire on grant when arbiter holds bid
// R8: slave acquires before response or deallocate
// R9: granted device may raise interrupt instead
// R10: lock on new acquisition or interrupt
// R11: arbiter drops grant on acquire or interrupt
// R12: arbiter drops grant on release, abort, reset
// R13: arbiter releases bid when bus idle
// R14: arbiter releases bid on deallocate, abort, reset
// R15: drop acquired after established cycle if done
// R16: drop acquired when arbiter withdrew bid
// R17: drop acquired after refused cycle
// R18: deallocating slave drops acquired; abort, reset too
// R19: release interrupt on grant low, abort, reset
// R20: unlock after master cycle and acquired release
// R21: unlock after interrupt, refusal, or reset
// R22: unlock after slave write or vector cycle
// R23: arbiter chooses among bidders by policy
module bah_device (
  input wire clock,
  input wire rstn,
  // Shared bus lines, active high inside the chip
  input wire bidLineIn,
  input wire grantLine,
  input wire acquiredLineIn,
  input wire cycleBeginLine,
  input wire cycleResponseLine,
  input wire cycleFinishLine,
  input wire cycleAbortLine,
  input wire generalResetLine,
  // Local master controls
  input wire needBus,
  input wire wantInterrupt,
  input wire moreCycles,
  input wire indivisibleOp,
  input wire masterCycleDone,
  input wire masterCycleStart,
  input wire drivingBegin,
  input wire drivingFinish,
  // Local slave controls
  input wire slaveAddressHit,
  input wire slaveWillDeallocate,
  input wire slaveIsCurrent,
  input wire slaveRefused,
  input wire slaveWriteVectorDone,
  input wire deallocDriving,
  // Line drives, open drain style, then lock flag and allocation state
  output reg bidLineOut,
  output reg bidLineOe,
  output reg acquiredLineOut,
  output reg acquiredLineOe,
  output reg interruptCycleLineOut,
  output reg interruptCycleLineOe,
  output reg locked,
  output reg [2:0] allocState
);

  // =========================================================
  // Line qualifiers
  wire busQuiet; // Grant and reset both quiet
  wire cycleIdle; // No transfer handshake in flight
  wire killAll; // Abort or reset present

  bah_cond uCond (
    .grantLine(grantLine),
    .cycleBeginLine(cycleBeginLine),
    .cycleResponseLine(cycleResponseLine),
    .cycleFinishLine(cycleFinishLine),
    .cycleAbortLine(cycleAbortLine),
    .generalResetLine(generalResetLine),
    .busQuiet(busQuiet),
    .cycleIdle(cycleIdle),
    .killAll(killAll)
  );

  // =========================================================
  // State and held lines
  reg [2:0] state_q; // Allocation state
  reg [2:0] state_d;
  reg bid_q; // Our own bid held
  reg bid_d;
  reg acq_q; // We hold acquired
  reg acq_d;
  reg intr_q; // We hold interrupt cycle line
  reg intr_d;
  reg lock_q; // Lock flag
  reg lock_d;
  reg cycleSeen_q; // A master cycle finished since acquire and no later master cycle start
  reg cycleSeen_d;

  // Bid line active but not by us: arbiter holds it
  wire arbHolds = bidLineIn & ~bid_q;
  // Cycle established by slave response
  wire established = cycleResponseLine;
  // Refused: bid line released while grant active
  wire refused = ~bidLineIn & grantLine;

  // =========================================================
  // Next state logic; lock set wins over every clear but reset
  always @* begin
    state_d = state_q;
    bid_d = bid_q;
    acq_d = acq_q;
    intr_d = intr_q;
    lock_d = lock_q;
    cycleSeen_d = cycleSeen_q;
    case (state_q)
      `BAH_ST_IDLE: begin
        // R1: bid gating
        if (needBus && !lock_q && busQuiet) begin
          bid_d = 1'b1;
          state_d = `BAH_ST_BID;
        end else if (slaveAddressHit && slaveWillDeallocate &&
            cycleBeginLine && !cycleResponseLine && !drivingFinish &&
            !killAll) begin
          // R8: slave acquires early
          // R3: response still quiet marks a refusal
          acq_d = 1'b1;
          state_d = `BAH_ST_SLAVE;
        end
      end
      `BAH_ST_BID: begin
        // R6: drop bid on grant or reset
        if (grantLine || generalResetLine) begin
          bid_d = 1'b0;
          state_d = generalResetLine ? `BAH_ST_IDLE : `BAH_ST_WAIT;
        end
      end
      `BAH_ST_WAIT: begin
        if (killAll || !grantLine) begin
          // Grant went away, or abort or reset came, before we took it
          state_d = `BAH_ST_IDLE;
        end else if (arbHolds && wantInterrupt) begin
          // R9: interrupt instead of acquire
          intr_d = 1'b1;
          // R10: lock on interrupt
          lock_d = 1'b1;
          state_d = `BAH_ST_INTR;
        end else if (arbHolds && cycleIdle) begin
          // R7: acquire on grant
          acq_d = 1'b1;
          // R10: lock on acquisition
          lock_d = 1'b1;
          cycleSeen_d = 1'b0;
          state_d = `BAH_ST_ACQ;
        end
      end
      `BAH_ST_ACQ: begin
        if (masterCycleDone) begin
          cycleSeen_d = 1'b1;
        end
        if (masterCycleStart) begin
          cycleSeen_d = 1'b0;
        end
        if (killAll) begin
          // R18: abort or reset drops acquired
          acq_d = 1'b0;
          state_d = `BAH_ST_IDLE;
        end else if (refused && !drivingBegin && !drivingFinish) begin
          // R17: refused cycle
          acq_d = 1'b0;
          // R21: unlock after refusal
          lock_d = 1'b0;
          state_d = `BAH_ST_IDLE;
        end else if (established &&
            ((bidLineIn && !moreCycles) ||
             (!bidLineIn && !indivisibleOp))) begin
          // R15: done with cycles; R16: arbiter withdrew bid
          acq_d = 1'b0;
          // R20: unlock if a cycle finished before release
          if (cycleSeen_q || masterCycleDone) begin
            lock_d = 1'b0;
          end
          state_d = `BAH_ST_IDLE;
        end
      end
      `BAH_ST_INTR: begin
        // R19: release interrupt
        if (!grantLine || killAll) begin
          intr_d = 1'b0;
          // R21: unlock on grant quiet
          if (!grantLine) begin
            lock_d = 1'b0;
          end
          state_d = `BAH_ST_IDLE;
        end
      end
      `BAH_ST_SLAVE: begin
        // R18: deallocating slave releases acquired
        if (killAll || (deallocDriving &&
            (slaveIsCurrent || (slaveRefused && grantLine)))) begin
          acq_d = 1'b0;
          state_d = `BAH_ST_IDLE;
        end
      end
      default: begin
        state_d = `BAH_ST_IDLE;
      end
    endcase
    // R20: master cycle completed while acquired is quiet
    if (masterCycleDone && !acq_q && !acqSetNow(state_d)) begin
      lock_d = 1'b0;
    end
    // R22: slave write or vector cycle completes
    if (slaveWriteVectorDone && !intr_q) begin
      lock_d = 1'b0;
    end
    // R10: a fresh lock this cycle wins over any clear except reset
    if (state_q == `BAH_ST_WAIT &&
        (state_d == `BAH_ST_ACQ || state_d == `BAH_ST_INTR)) begin
      lock_d = 1'b1;
    end
    // R21: reset clears lock
    if (generalResetLine) begin
      lock_d = 1'b0;
      bid_d = 1'b0;
      acq_d = 1'b0;
      intr_d = 1'b0;
      state_d = `BAH_ST_IDLE;
    end
  end

  // True when the next state holds acquired as master
  function acqSetNow;
    input [2:0] st;
    begin
      acqSetNow = (st == `BAH_ST_ACQ);
    end
  endfunction

  // =========================================================
  // Registers; every output comes straight from a flop
  always @(posedge clock) begin
    if (!rstn) begin
      state_q <= `BAH_ST_IDLE;
      bid_q <= `BAH_RST_BIT;
      acq_q <= `BAH_RST_BIT;
      intr_q <= `BAH_RST_BIT;
      lock_q <= `BAH_RST_BIT;
      cycleSeen_q <= `BAH_RST_BIT;
      bidLineOut <= `BAH_RST_BIT;
      bidLineOe <= `BAH_RST_BIT;
      acquiredLineOut <= `BAH_RST_BIT;
      acquiredLineOe <= `BAH_RST_BIT;
      interruptCycleLineOut <= `BAH_RST_BIT;
      interruptCycleLineOe <= `BAH_RST_BIT;
      locked <= `BAH_RST_BIT;
      allocState <= `BAH_ST_IDLE;
    end else begin
      state_q <= state_d;
      bid_q <= bid_d;
      acq_q <= acq_d;
      intr_q <= intr_d;
      lock_q <= lock_d;
      cycleSeen_q <= cycleSeen_d;
      // Open drain: drive active level only while held
      bidLineOut <= bid_d;
      bidLineOe <= bid_d;
      acquiredLineOut <= acq_d;
      acquiredLineOe <= acq_d;
      interruptCycleLineOut <= intr_d;
      interruptCycleLineOe <= intr_d;
      locked <= lock_d;
      allocState <= state_d;
    end
  end

endmodule

`default_nettype wire

// [verilog/bah_map.vh]
// Shared constants for the bus allocation handshake device end
`ifndef BAH_MAP_VH
`define BAH_MAP_VH

// Allocation state codes
`define BAH_ST_IDLE 3'h0
`define BAH_ST_BID 3'h1
`define BAH_ST_WAIT 3'h2
`define BAH_ST_ACQ 3'h3
`define BAH_ST_INTR 3'h4
`define BAH_ST_SLAVE 3'h5

// Reset value of every control flop
`define BAH_RST_BIT 1'h0

`endif

// [verilog/bah_cond.v]
// Combinational qualifiers derived from the shared handshake lines
`timescale 1ns/1ps
`default_nettype none

module bah_cond (
  input wire grantLine,
  input wire cycleBeginLine,
  input wire cycleResponseLine,
  input wire cycleFinishLine,
  input wire cycleAbortLine,
  input wire generalResetLine,
  output wire busQuiet,
  output wire cycleIdle,
  output wire killAll
);

  // =========================================================
  // Line qualifiers
  // Abort or reset forces acquired and interrupt to drop; only reset drops bid
  assign killAll = cycleAbortLine | generalResetLine;
  // Transfer handshake fully at rest
  assign cycleIdle = ~cycleBeginLine & ~cycleResponseLine &
    ~cycleFinishLine;
  // Nothing on the bus stops a new bid
  assign busQuiet = ~grantLine & ~generalResetLine;

endmodule

`default_nettype wire

// [tb/bah_arb_model.sv]
// Behavioural arbiter facing one device end
`timescale 1ns/1ps
`default_nettype none
// ====
// Arbiter model
module bah_arb_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic bidLine,
  input wire logic acquired,
  input wire logic intr,
  input wire logic withdraw,
  input wire logic stall,
  output logic grant,
  output logic hold
);
  // Stall delays allocation so slow answers are exercised
  always @(posedge clock) begin
    if (!rstn || withdraw) begin
      grant <= 1'b0;
      hold <= 1'b0;
    end else if (bidLine && !hold && !grant && !acquired && !intr && !stall) begin
      hold <= 1'b1;
      grant <= 1'b1;
    end else if (grant && (acquired || intr)) begin
      grant <= 1'b0;
    end else if (hold && !grant && !acquired && !intr) begin
      hold <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tb/bah_dev_chk.sv]
// Checker of the device end allocation handshake
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker
module bah_dev_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic bidLineIn,
  input wire logic grantLine,
  input wire logic cycleResponseLine,
  input wire logic cycleAbortLine,
  input wire logic generalResetLine,
  input wire logic needBus,
  input wire logic moreCycles,
  input wire logic bidLineOut,
  input wire logic acquiredLineOut,
  input wire logic interruptCycleLineOut,
  input wire logic locked
);
  // One domain, synchronous reset
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rstn);
  bid_free_a: assert property (
    $rose(bidLineOut) |-> $past(needBus && !locked && !grantLine
    && !generalResetLine)) else $error("bid raised while barred");
  bid_drop_a: assert property (
    bidLineOut && (grantLine || generalResetLine) |=> !bidLineOut)
    else $error("bid kept");
  acq_rise_a: assert property (
    $rose(acquiredLineOut) |-> $past(!cycleAbortLine && !generalResetLine))
    else $error("acquired during abort");
  intr_rise_a: assert property (
    $rose(interruptCycleLineOut) |-> $past(grantLine && bidLineIn))
    else $error("interrupt without grant");
  lock_set_a: assert property (
    $rose(interruptCycleLineOut) || ($rose(acquiredLineOut) && bidLineIn)
    |-> locked)
    else $error("lock not set");
  acq_done_a: assert property (
    acquiredLineOut && cycleResponseLine && bidLineIn && !moreCycles
    |=> !acquiredLineOut) else $error("acquired kept");
  acq_kill_a: assert property (
    acquiredLineOut && (cycleAbortLine || generalResetLine)
    |=> !acquiredLineOut) else $error("acquired kept on abort");
  intr_rel_a: assert property (
    interruptCycleLineOut && !grantLine |=> !interruptCycleLineOut)
    else $error("interrupt kept");
  rst_clr_a: assert property (
    generalResetLine |=> !locked && !bidLineOut)
    else $error("reset did not clear");
endmodule
bind bah_device bah_dev_chk chk (.*);
`default_nettype wire

// [tb/tb_top.sv]
// Testbench of the device end allocation handshake
`timescale 1ns/1ps
`default_nettype none
`include "bah_map.vh"
module tb_top;
  // ====
  // Stimulus and wiring
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic needBus = 1'b0, wantInterrupt = 1'b0, moreCycles = 1'b0;
  logic cycleResponseLine = 1'b0, cycleAbortLine = 1'b0, stall = 1'b0;
  logic generalResetLine = 1'b0, masterCycleDone = 1'b0;
  // Slave side and cycle lines stay quiet in this bench except where t_slave drives them
  logic cycleBeginLine = 1'b0, cycleFinishLine = 1'b0;
  logic indivisibleOp = 1'b0, masterCycleStart = 1'b0;
  logic drivingBegin = 1'b0, drivingFinish = 1'b0, deallocDriving = 1'b0;
  logic slaveAddressHit = 1'b0, slaveWillDeallocate = 1'b0;
  logic slaveIsCurrent = 1'b0, slaveRefused = 1'b0;
  logic slaveWriteVectorDone = 1'b0;
  wire bidLineOut, bidLineOe, acquiredLineOut, acquiredLineOe;
  wire interruptCycleLineOut, interruptCycleLineOe, locked, grantLine, hold;
  wire [2:0] allocState;
  // Wired-or bid line: device or arbiter holds it
  wire bidLineIn = bidLineOut | hold;
  wire acquiredLineIn = acquiredLineOut;
  int errors = 0;
  int tests_run = 0;
  bah_device dut (.*);
  bah_arb_model arb (.clock(clock), .rstn(rstn), .bidLine(bidLineIn),
    .acquired(acquiredLineOut), .intr(interruptCycleLineOut),
    .withdraw(cycleAbortLine | generalResetLine), .stall(stall),
    .grant(grantLine), .hold(hold));
  initial forever #20 clock = ~clock;
  // ====
  // Shared tasks
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bid with a slow arbiter, wait for acquire or interrupt
  task automatic getBus(input logic intr);
    @(posedge clock);
    needBus <= 1'b1;
    wantInterrupt <= intr;
    stall <= 1'b1;
    repeat (4) @(posedge clock);
    stall <= 1'b0;
    repeat (20) if ((intr ? interruptCycleLineOut : acquiredLineOut) !== 1'b1)
      @(negedge clock);
  endtask
  // ====
  // Scenarios
  task automatic t_master;
    getBus(1'b0);
    chk(allocState, `BAH_ST_ACQ);
    chk(locked, 1'b1);
    chk({acquiredLineOe, bidLineOe, interruptCycleLineOe}, 3'h4);
    repeat (3) @(negedge clock);
    chk(bidLineOut, 1'b0);
    @(posedge clock);
    masterCycleDone <= 1'b1;
    @(posedge clock);
    masterCycleDone <= 1'b0;
    cycleResponseLine <= 1'b1;
    needBus <= 1'b0;
    repeat (2) @(negedge clock);
    chk(acquiredLineOut, 1'b0);
    chk(locked, 1'b0);
    @(posedge clock);
    cycleResponseLine <= 1'b0;
    $display("t_master done");
  endtask
  task automatic t_intr;
    getBus(1'b1);
    chk({acquiredLineOut, interruptCycleLineOut, locked}, 3'h3);
    chk(interruptCycleLineOe, 1'b1);
    @(posedge clock);
    needBus <= 1'b0;
    wantInterrupt <= 1'b0;
    repeat (10) if (interruptCycleLineOut !== 1'b0) @(negedge clock);
    @(negedge clock);
    chk({interruptCycleLineOut, locked, bidLineOut}, 3'h0);
    $display("t_intr done");
  endtask
  // Addressed slave acquires ahead of deallocating, then lets go
  task automatic t_slave;
    @(posedge clock);
    slaveAddressHit <= 1'b1;
    slaveWillDeallocate <= 1'b1;
    cycleBeginLine <= 1'b1;
    repeat (2) @(negedge clock);
    chk(allocState, `BAH_ST_SLAVE);
    chk({acquiredLineOut, acquiredLineOe, locked}, 3'h6);
    @(posedge clock);
    deallocDriving <= 1'b1;
    slaveIsCurrent <= 1'b1;
    repeat (2) @(negedge clock);
    chk({acquiredLineOut, acquiredLineOe}, 3'h0);
    @(posedge clock);
    slaveAddressHit <= 1'b0;
    slaveWillDeallocate <= 1'b0;
    cycleBeginLine <= 1'b0;
    deallocDriving <= 1'b0;
    slaveIsCurrent <= 1'b0;
    repeat (2) @(posedge clock);
    $display("t_slave done");
  endtask
  task automatic t_kill;
    getBus(1'b0);
    @(posedge clock);
    needBus <= 1'b0;
    cycleAbortLine <= 1'b1;
    @(posedge clock);
    cycleAbortLine <= 1'b0;
    generalResetLine <= 1'b1;
    needBus <= 1'b1;
    @(negedge clock);
    chk(acquiredLineOut, 1'b0);
    @(negedge clock);
    chk({locked, bidLineOut}, 3'h0);
    @(posedge clock);
    generalResetLine <= 1'b0;
    repeat (2) @(negedge clock);
    chk(bidLineOut, 1'b1);
    $display("t_kill done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog: 1000 cycles, far beyond the few dozen needed
  initial begin
    #40000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_master();
    t_intr();
    t_slave();
    t_kill();
    end_of_test();
  end
endmodule
`default_nettype wire
